// >>> core/plwit_pkg.sv
// What this block does
// - Select code 0..6 gives 2^12..2^18 cycles, code 7 gives 2^20.
// - Reset clears period select register; upper five bits always zero.
// - Reset clears mode register: stopped, interval mode, sticky bits free.
// - Run bit 0 holds count; each write of 1 clears and starts.
// - Once run is set, software writes of 0 are ignored.
// - Once mode bits are 1, software writes of 0 are ignored.
// - Upper mode bit 0 means interval timer; overflow raises interval request.
// - Mode bits 1,0 mean watchdog mode 1; overflow raises NMI request.
// - Mode bits 1,1 mean watchdog mode 2; overflow raises system reset.
// - First overflow after restart may be up to 2^8 cycles early.
// - Interval mode repeats requests every period without software help.
// - Interval request is gated by its mask flag only; priority flag is just passed through.
// - Counter runs in HALT and freezes in STOP, in all modes.
// - Counter halts while CPU runs from subsystem clock.
// - Interval request ranks highest among maskable sources at default.
// - Counter advances on main clock; overflows at carry of selected bit.
// - Watchdog and interval modes are exclusive; never both at once.
package plwit_pkg;
  localparam logic [15:0] PLWIT_PERIOD_SEL_ADDR = 16'hFF42;
  localparam logic [15:0] PLWIT_MODE_CTRL_ADDR  = 16'hFFF9;
  localparam logic [7:0]  PLWIT_REG_RESET       = 8'h00;
  localparam int          PLWIT_RUN_BIT         = 7;
  localparam int          PLWIT_LOOP_BIT        = 4;
  localparam int          PLWIT_RSTSEL_BIT      = 3;
  localparam int          PLWIT_PRESC_W         = 8;
  localparam int          PLWIT_CNT_W           = 12;
  localparam logic [2:0]  PLWIT_SEL_MAX         = 3'h7;
  localparam logic [PLWIT_CNT_W-1:0] PLWIT_CNT_ZERO = 12'h000;

  typedef enum logic [1:0] {
    PLWIT_MODE_INTERVAL = 2'b00,
    PLWIT_MODE_NMI      = 2'b01,
    PLWIT_MODE_RESET    = 2'b10
  } plwit_mode_t;

  typedef struct packed {
    logic interval_irq;
    logic nmi_req;
    logic reset_req;
  } plwit_events_t;
endpackage

// >>> core/plwit_prescaler.sv
module plwit_prescaler (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic enable,
  output logic      tick
);
  logic [plwit_pkg::PLWIT_PRESC_W-1:0] presc_reg;

  // Never cleared by run writes, so first period may be short
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      presc_reg <= '0;
    end else if (enable) begin
      presc_reg <= presc_reg + 1'b1;
    end
  end

  assign tick = enable && (presc_reg == '1);
endmodule

// >>> core/plwit_apb_regs.sv
module plwit_apb_regs (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [2:0]  period_sel,
  output logic             run,
  output logic             loop_detect_select,
  output logic             overflow_reset_select,
  output logic             run_write
);
  logic        access;
  logic        commit;
  logic        hit_sel;
  logic        hit_mode;
  logic        ready_reg;
  logic        err_reg;
  logic [31:0] rdata_c;
  logic [31:0] rdata_reg;

  assign access    = psel && penable;
  assign commit    = access && ready_reg;
  assign hit_sel   = paddr == plwit_pkg::PLWIT_PERIOD_SEL_ADDR;
  assign hit_mode  = paddr == plwit_pkg::PLWIT_MODE_CTRL_ADDR;
  assign pready    = ready_reg;
  assign pslverr   = err_reg;
  assign prdata    = rdata_reg;
  assign run_write = commit && pwrite && hit_mode && pwdata[plwit_pkg::PLWIT_RUN_BIT];

  // One wait state buys registered bus outputs; writes land only on the ready edge
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ready_reg <= 1'b0;
      err_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ready_reg <= access && !ready_reg;
      err_reg   <= access && !ready_reg && !(hit_sel || hit_mode);
      rdata_reg <= (access && !ready_reg) ? rdata_c : 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      period_sel <= plwit_pkg::PLWIT_REG_RESET[2:0];
    end else if (commit && pwrite && hit_sel) begin
      period_sel <= pwdata[2:0];
    end
  end

  // Sticky bits: software can set, only reset clears
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      run                   <= 1'b0;
      loop_detect_select    <= 1'b0;
      overflow_reset_select <= 1'b0;
    end else if (commit && pwrite && hit_mode) begin
      run                   <= run | pwdata[plwit_pkg::PLWIT_RUN_BIT];
      loop_detect_select    <= loop_detect_select | pwdata[plwit_pkg::PLWIT_LOOP_BIT];
      overflow_reset_select <= overflow_reset_select | pwdata[plwit_pkg::PLWIT_RSTSEL_BIT];
    end
  end

  always_comb begin
    rdata_c = 32'h0000_0000;
    if (hit_sel) begin
      rdata_c[2:0] = period_sel;
    end else if (hit_mode) begin
      rdata_c[plwit_pkg::PLWIT_RUN_BIT]    = run;
      rdata_c[plwit_pkg::PLWIT_LOOP_BIT]   = loop_detect_select;
      rdata_c[plwit_pkg::PLWIT_RSTSEL_BIT] = overflow_reset_select;
    end
  end
endmodule

// >>> core/plwit_top.sv
module plwit_top (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        stop_mode,
  input  wire logic        subsys_clk_sel,
  input  wire logic        interval_irq_mask,
  input  wire logic        interval_irq_priority,
  output logic             interval_irq,
  output logic             interval_irq_priority_out,
  output logic             nmi_req,
  output logic             reset_req
);
  localparam int PLWIT_CNT_W_L = plwit_pkg::PLWIT_CNT_W;

  logic        stop_s1_reg;
  logic        stop_s2_reg;
  logic        sub_s1_reg;
  logic        sub_s2_reg;
  logic [2:0]  period_sel;
  logic        run;
  logic        loop_sel;
  logic        rst_sel;
  logic        run_write;
  logic        count_en;
  logic        tick;
  logic [PLWIT_CNT_W_L-1:0] cnt_reg;
  logic        ovf;
  plwit_pkg::plwit_mode_t mode;
  logic [31:0] prdata_c;
  logic        pslverr_c;
  logic        pready_c;

  plwit_pkg::plwit_events_t events_next;
  plwit_pkg::plwit_events_t events_reg;
  logic                     prio_reg;

  // Carry-out of the selected counter bit, one prescaled tick (2^8 cycles) per count
  function automatic logic sel_carry(input logic [PLWIT_CNT_W_L-1:0] c, input logic [2:0] s);
    logic r;
    r = 1'b0;
    case (s)
      3'h0:    r = &c[3:0];
      3'h1:    r = &c[4:0];
      3'h2:    r = &c[5:0];
      3'h3:    r = &c[6:0];
      3'h4:    r = &c[7:0];
      3'h5:    r = &c[8:0];
      3'h6:    r = &c[9:0];
      default: r = &c[11:0];
    endcase
    return r;
  endfunction

  // Overflow survives only if no kick lands in the same cycle
  function automatic logic req_for(input logic                   o,
                                   input logic                   k,
                                   input plwit_pkg::plwit_mode_t m,
                                   input plwit_pkg::plwit_mode_t want);
    return o && !k && (m == want);
  endfunction

  plwit_apb_regs u_regs (
    .mclk                  (mclk),
    .rst_n                 (rst_n),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .prdata                (prdata_c),
    .pready                (pready_c),
    .pslverr               (pslverr_c),
    .period_sel            (period_sel),
    .run                   (run),
    .loop_detect_select    (loop_sel),
    .overflow_reset_select (rst_sel),
    .run_write             (run_write)
  );

  // Bus outputs are flops in the register bank, one wait state per access
  assign prdata  = prdata_c;
  assign pready  = pready_c;
  assign pslverr = pslverr_c;

  // Standby and clock-select inputs come from other logic domains
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stop_s1_reg <= 1'b0;
      stop_s2_reg <= 1'b0;
      sub_s1_reg  <= 1'b0;
      sub_s2_reg  <= 1'b0;
    end else begin
      stop_s1_reg <= stop_mode;
      stop_s2_reg <= stop_s1_reg;
      sub_s1_reg  <= subsys_clk_sel;
      sub_s2_reg  <= sub_s1_reg;
    end
  end

  assign count_en = run && !stop_s2_reg && !sub_s2_reg;

  plwit_prescaler u_presc (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .enable (count_en),
    .tick   (tick)
  );

  // One mode only; upper bit 0 forces interval whatever lower holds
  always_comb begin
    case ({loop_sel, rst_sel})
      2'b10:   mode = plwit_pkg::PLWIT_MODE_NMI;
      2'b11:   mode = plwit_pkg::PLWIT_MODE_RESET;
      default: mode = plwit_pkg::PLWIT_MODE_INTERVAL;
    endcase
  end

  assign ovf = tick && sel_carry(cnt_reg, period_sel);

  // Run write wins over overflow: a kick in the overflow cycle saves the system
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_reg <= plwit_pkg::PLWIT_CNT_ZERO;
    end else if (run_write) begin
      cnt_reg <= plwit_pkg::PLWIT_CNT_ZERO;
    end else if (ovf) begin
      cnt_reg <= plwit_pkg::PLWIT_CNT_ZERO;
    end else if (tick) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Mask only gates the interval request; NMI and reset are unmaskable
  always_comb begin
    events_next              = '0;
    events_next.interval_irq = req_for(ovf, run_write, mode, plwit_pkg::PLWIT_MODE_INTERVAL)
                               && !interval_irq_mask;
    events_next.nmi_req      = req_for(ovf, run_write, mode, plwit_pkg::PLWIT_MODE_NMI);
    events_next.reset_req    = req_for(ovf, run_write, mode, plwit_pkg::PLWIT_MODE_RESET);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      events_reg <= '0;
    end else begin
      events_reg <= events_next;
    end
  end

  // Priority is only carried through; ranking lives in the interrupt controller
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prio_reg <= 1'b0;
    end else begin
      prio_reg <= interval_irq_priority;
    end
  end

  assign interval_irq              = events_reg.interval_irq;
  assign nmi_req                   = events_reg.nmi_req;
  assign reset_req                 = events_reg.reset_req;
  assign interval_irq_priority_out = prio_reg;
endmodule

// >>> test/plwit_checker.sv
module plwit_checker (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        stop_mode,
  input wire logic        subsys_clk_sel,
  input wire logic        interval_irq_mask,
  input wire logic        interval_irq_priority,
  input wire logic        interval_irq,
  input wire logic        interval_irq_priority_out,
  input wire logic        nmi_req,
  input wire logic        reset_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire logic       acc    = psel && penable;
  wire logic       rd     = acc && !pwrite;
  wire logic       mapped = paddr == 16'hFF42 || paddr == 16'hFFF9;
  wire logic [2:0] ev     = {interval_irq, nmi_req, reset_req};
  ready_wait_a: assert property (acc && !pready |=> pready) else $error("access not ready");
  unmapped_err_a: assert property (acc && pready |-> pslverr == !mapped) else $error("wrong error flag");
  sel_read_a: assert property (rd && pready && paddr == 16'hFF42 |-> prdata[31:3] == 29'h0)
    else $error("sel top bits");
  mode_read_a: assert property (rd && pready && paddr == 16'hFFF9 |-> (prdata & 32'hFFFFFF67) == 32'h0)
    else $error("mode bits");
  single_pulse_a: assert property (|ev |=> ev == 3'h0) else $error("request too long");
  mode_excl_a: assert property ($onehot0(ev)) else $error("two requests at once");
  mask_gate_a: assert property (interval_irq |-> !$past(interval_irq_mask)) else $error("masked irq");
  prio_copy_a: assert property ($past(rst_n) |-> interval_irq_priority_out == $past(interval_irq_priority))
    else $error("prio");
  stop_freeze_a: assert property (stop_mode [*5] |=> ev == 3'h0) else $error("request in stop");
  subsys_halt_a: assert property (subsys_clk_sel [*5] |=> ev == 3'h0) else $error("request on subclock");
  irq_seen_c: cover property (interval_irq);
  nmi_seen_c: cover property (nmi_req);
  rst_seen_c: cover property (reset_req);
endmodule
bind plwit_top plwit_checker plwit_checker_inst (.*);

// >>> test/plwit_top_tb.sv
`define CHK(nm, e, s) begin cmp_count++; if ((e) !== (s)) begin num_errors++; $display("BAD %s exp %0h got %0h", nm, e, s); end end
module plwit_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 0;
  logic        rst_n = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic        stop_mode = 0;
  logic        subsys_clk_sel = 0;
  logic        interval_irq_mask = 0;
  logic        interval_irq_priority = 0;
  logic [31:0] prdata;
  logic        pready, pslverr, interval_irq, interval_irq_priority_out, nmi_req, reset_req;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          n;
  int          seed = 32'h36A7;
  logic [7:0]  sel_m = 8'h00;
  logic [7:0]  mode_m = 8'h00;
  logic [31:0] r;
  logic        e;
  logic [2:0]  ev;
  plwit_top plwit_top_inst (.*);
  always #50 mclk = ~mclk;
  // Long hang guard; the whole run needs about 45k cycles
  always @(posedge mclk) begin
    interval_irq_priority <= 1'($random(seed));
    cyc++;
    if (cyc == 70000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Register model mirrors the sticky bits
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (w && a == 16'hFF42) sel_m = d[7:0] & 8'h07;
    if (w && a == 16'hFFF9) mode_m = mode_m | (d[7:0] & 8'h98);
  endtask
  task automatic wait_ev(input int lim);
    ev = 3'b000;
    for (n = 1; n <= lim; n++) begin
      @(posedge mclk);
      ev = {interval_irq, nmi_req, reset_req};
      if (ev !== 3'b000) break;
    end
  endtask
  function automatic int per();
    return (sel_m == 8'h07) ? (1 << 20) : (1 << (12 + sel_m));
  endfunction
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1;
    apb(0, 16'hFF42, 0);
    `CHK("sel_rst", {24'h0, sel_m}, r)
    apb(0, 16'hFFF9, 0);
    `CHK("mode_rst", {24'h0, mode_m}, r)
    apb(0, 16'hFF43, 0);
    `CHK("unmapped", 1'b1, e)
    for (int c = 0; c < 8; c++) begin
      apb(1, 16'hFF42, $random(seed) & ~32'h7 | c);
      apb(0, 16'hFF42, 0);
      `CHK("sel_rd", {24'h0, sel_m}, r)
    end
    apb(1, 16'hFF42, 0);
    $display("test registers done");
    apb(1, 16'hFFF9, 32'h80);
    wait_ev(per() + 100);
    `CHK("first_ok", 1'b1, n >= per() - 256 && n <= per() + 2)
    `CHK("irq_kind", 3'b100, ev)
    wait_ev(per() + 100);
    `CHK("period", per(), n)
    apb(1, 16'hFFF9, 0);
    apb(0, 16'hFFF9, 0);
    `CHK("run_sticky", {24'h0, mode_m}, r)
    interval_irq_mask <= 1;
    wait_ev(per() + 100);
    `CHK("masked", 3'b000, ev)
    interval_irq_mask <= 0;
    apb(1, 16'hFFF9, 32'h80);
    stop_mode <= 1;
    repeat (4) @(posedge mclk);
    wait_ev(per() + 900);
    `CHK("stop", 3'b000, ev)
    stop_mode <= 0;
    subsys_clk_sel <= 1;
    wait_ev(per() + 900);
    `CHK("subsys", 3'b000, ev)
    subsys_clk_sel <= 0;
    $display("test interval done");
    apb(1, 16'hFFF9, 32'h90);
    repeat (3) begin
      wait_ev(per() - 600);
      `CHK("kicked", 3'b000, ev)
      apb(1, 16'hFFF9, 32'h90);
    end
    wait_ev(per() + 100);
    `CHK("nmi", 3'b010, ev)
    apb(1, 16'hFFF9, 0);
    apb(0, 16'hFFF9, 0);
    `CHK("mode_sticky", {24'h0, mode_m}, r)
    apb(1, 16'hFFF9, 32'h98);
    wait_ev(per() + 100);
    `CHK("reset", 3'b001, ev)
    $display("test watchdog done");
    rst_n <= 0;
    repeat (10) @(posedge mclk);
    rst_n <= 1;
    sel_m = 8'h00;
    mode_m = 8'h00;
    apb(0, 16'hFFF9, 0);
    `CHK("mode_rst2", {24'h0, mode_m}, r)
    wait_ev(per() + 100);
    `CHK("stopped", 3'b000, ev)
    $display("test reset done");
    print_verdict();
  end
endmodule
